// file: logic/uart_pkg.sv
// Shared constants and carrier types for the serial transceiver core.
// Assumes a single 25 MHz clock and an AXI4-Lite master on the register side.

package uart_pkg;

  // ----------------------------------------------------------------
  // Buffer geometry
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DIVISOR = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_INT_ID = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h14;
  localparam logic [15:0] DIVISOR_RESET = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Interrupt sources, one bit each in status and mask
  // ----------------------------------------------------------------
  localparam int INT_W = 4;
  localparam int INT_RX = 0;
  localparam int INT_TX_EMPTY = 1;
  localparam int INT_LINE = 2;
  localparam int INT_OVR = 3;

  // ----------------------------------------------------------------
  // Bit timing in reference ticks, as last index of a count from zero
  // ----------------------------------------------------------------
  localparam logic [4:0] OS16_LAST = 5'h0F;
  localparam logic [4:0] OS13_LAST = 5'h0C;
  localparam logic [4:0] SAMPLE16 = 5'h07;
  localparam logic [4:0] SAMPLE13 = 5'h05;
  localparam logic [4:0] HALF16_LAST = 5'h07;
  localparam logic [4:0] HALF13_LAST = 5'h06;
  localparam logic [4:0] TICK_ONE = 5'h01;
  localparam logic [2:0] BITS_BASE = 3'h4;
  localparam logic [2:0] BITS_PAD = 3'h3;

  // Control register layout, high bits first.
  typedef struct packed {
    logic even_par;
    logic par_en;
    logic two_stop;
    logic [1:0] wlen;
    logic osm13;
    logic fifo_mode;
  } cfg_t;

  // One receive buffer entry: three error bits travel with the byte.
  typedef struct packed {
    logic brk;
    logic frame_err;
    logic par_err;
    logic [7:0] data;
  } rx_entry_t;

endpackage

// file: logic/entry_fifo.sv
// Sixteen-entry first-in first-out store, optionally limited to one entry.
// A push while push_ready is low is ignored, so writers need not wait for it.
`timescale 1ns/1ps
`default_nettype none

module entry_fifo #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic flush,
  input wire logic single,
  input wire logic push_valid,
  output logic push_ready,
  input wire logic [WIDTH-1:0] push_data,
  output logic pop_valid,
  input wire logic pop_ready,
  output logic [WIDTH-1:0] pop_data,
  output logic [uart_pkg::CNT_W-1:0] count
);
  import uart_pkg::*;

  logic [WIDTH-1:0] mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  wire logic push_fire;
  wire logic pop_fire;

  // ----------------------------------------------------------------
  // Handshake decode
  // ----------------------------------------------------------------
  // In single mode the store acts as a one-entry holding register.
  assign push_ready = single ? (count == CNT_ZERO) : (count != CNT_FULL);
  assign pop_valid = (count != CNT_ZERO);
  assign pop_data = mem[rd_ptr];
  assign push_fire = push_valid && push_ready;
  assign pop_fire = pop_valid && pop_ready;

  // Storage has no reset; only the pointers and the count define what is valid.
  always_ff @(posedge clk) begin
    if (push_fire) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // Pointers and occupancy; flush wins so a mode change starts clean.
  always_ff @(posedge clk) begin
    if (reset || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= CNT_ZERO;
    end else begin
      if (push_fire) begin
        wr_ptr <= wr_ptr + PTR_ONE;
      end
      if (pop_fire) begin
        rd_ptr <= rd_ptr + PTR_ONE;
      end
      if (push_fire && !pop_fire) begin
        count <= count + CNT_ONE;
      end else if (pop_fire && !push_fire) begin
        count <= count - CNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fifo_bound: assert property (@(posedge clk) disable iff (reset)
    count <= CNT_FULL)
    else $error("fifo holds more than sixteen entries");

  a_single_char_limit: assert property (@(posedge clk) disable iff (reset)
    (single && !$past(flush)) |-> count <= CNT_ONE)
    else $error("single mode buffered more than one entry");

endmodule
`default_nettype wire

// file: logic/uart_fifo_baud_core.sv
// Serial transceiver core with baud divider, buffers and interrupt logic.
// Assumes an AXI4-Lite master, one clock and inputs synchronous to it.
`timescale 1ns/1ps
`default_nettype none

module uart_fifo_baud_core (
  input wire logic clk,
  input wire logic reset,
  input wire logic awvalid,
  output logic awready,
  input wire logic [uart_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [uart_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  import uart_pkg::*;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  cfg_t cfg;
  logic [15:0] divisor;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [15:0] baud_cnt;
  logic baud_tick;
  tx_state_t tx_state;
  logic [4:0] tx_tick;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  logic tx_par;
  rx_state_t rx_state;
  logic [4:0] rx_tick;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_par;
  logic rx_par_err;
  logic rxd_prev;
  logic rx_push_valid;
  rx_entry_t rx_entry;
  wire logic tx_push_ready;
  wire logic tx_pop_valid;
  wire logic [7:0] tx_pop_data;
  wire logic [CNT_W-1:0] tx_count;
  wire logic rx_push_ready;
  wire logic rx_pop_valid;
  wire rx_entry_t rx_pop_data;
  wire logic [CNT_W-1:0] rx_count;

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  // A write is performed once both address and data are held.
  wire logic write_fire = aw_held && w_held && !bvalid;
  wire logic read_fire = arvalid && arready;
  wire logic wr_data = write_fire && (aw_addr == ADDR_DATA);
  wire logic wr_ctrl = write_fire && (aw_addr == ADDR_CTRL) && w_strb[0];
  wire logic wr_div = write_fire && (aw_addr == ADDR_DIVISOR);
  wire logic wr_mask = write_fire && (aw_addr == ADDR_INT_MASK) && w_strb[0];
  wire logic wr_known = (aw_addr == ADDR_DATA) || (aw_addr == ADDR_CTRL)
    || (aw_addr == ADDR_DIVISOR) || (aw_addr == ADDR_STATUS)
    || (aw_addr == ADDR_INT_ID) || (aw_addr == ADDR_INT_MASK);
  wire logic rd_known = (araddr == ADDR_DATA) || (araddr == ADDR_CTRL)
    || (araddr == ADDR_DIVISOR) || (araddr == ADDR_STATUS)
    || (araddr == ADDR_INT_ID) || (araddr == ADDR_INT_MASK);
  wire logic rd_data = read_fire && (araddr == ADDR_DATA);
  wire logic rd_int_id = read_fire && (araddr == ADDR_INT_ID);
  wire cfg_t next_cfg = cfg_t'(w_data[6:0]);
  wire logic mode_flush = wr_ctrl && (next_cfg.fifo_mode != cfg.fifo_mode);
  wire logic tx_push_fire = wr_data && w_strb[0] && tx_push_ready;
  wire logic [31:0] status_word = {11'h000, tx_count, 3'h0, rx_count, 4'h0,
    tx_state == TX_IDLE && !tx_pop_valid, !tx_push_ready, !tx_pop_valid, rx_pop_valid};
  wire logic [31:0] rd_word =
    (araddr == ADDR_DATA) ? (rx_pop_valid ? {21'h00_0000, rx_pop_data} : 32'h0000_0000) :
    (araddr == ADDR_CTRL) ? {25'h000_0000, cfg} :
    (araddr == ADDR_DIVISOR) ? {16'h0000, divisor} :
    (araddr == ADDR_STATUS) ? status_word :
    (araddr == ADDR_INT_ID) ? {28'h000_0000, int_status} :
    (araddr == ADDR_INT_MASK) ? {28'h000_0000, int_mask} : 32'h0000_0000;

  // Write channels: address and data are taken in either order.
  always_ff @(posedge clk) begin
    if (reset) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (!aw_held && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (!w_held && !bvalid) begin
        wready <= 1'b1;
      end
      if (write_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel: data is captured at the address handshake, so status
  // is answered at once whatever the serial side is doing.
  always_ff @(posedge clk) begin
    if (reset) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (read_fire) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Software settings; divisor bytes honour their own strobes.
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg <= '0;
      divisor <= DIVISOR_RESET;
      int_mask <= '0;
    end else begin
      if (wr_ctrl) begin
        cfg <= next_cfg;
      end
      if (wr_div && w_strb[0]) begin
        divisor[7:0] <= w_data[7:0];
      end
      if (wr_div && w_strb[1]) begin
        divisor[15:8] <= w_data[15:8];
      end
      if (wr_mask) begin
        int_mask <= w_data[INT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Baud reference
  // ----------------------------------------------------------------
  // A divisor of zero behaves as one rather than stalling the link.
  wire logic [15:0] div_last = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
  wire logic [4:0] os_last = cfg.osm13 ? OS13_LAST : OS16_LAST;
  wire logic [4:0] sample_pt = cfg.osm13 ? SAMPLE13 : SAMPLE16;
  wire logic [4:0] half_last = cfg.osm13 ? HALF13_LAST : HALF16_LAST;
  wire logic [2:0] bits_last = BITS_BASE + {1'b0, cfg.wlen};

  always_ff @(posedge clk) begin
    if (reset || baud_cnt >= div_last) begin
      baud_cnt <= 16'h0000;
      baud_tick <= !reset;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
      baud_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // The half stop bit only applies to five-bit words with two stops.
  wire logic tx_half = (tx_state == TX_STOP) && tx_bit[0] && (cfg.wlen == 2'h0);
  wire logic tx_end = baud_tick && (tx_tick == (tx_half ? half_last : os_last));
  wire logic tx_pop_fire = (tx_state == TX_IDLE) && tx_pop_valid;

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state <= TX_IDLE;
      txd <= 1'b1;
      tx_tick <= 5'h00;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      tx_par <= 1'b0;
    end else begin
      if (baud_tick) begin
        tx_tick <= tx_end ? 5'h00 : tx_tick + TICK_ONE;
      end
      case (tx_state)
        TX_IDLE: begin
          txd <= 1'b1;
          if (tx_pop_valid) begin
            tx_state <= TX_START;
            txd <= 1'b0;
            tx_tick <= 5'h00;
            tx_shift <= tx_pop_data;
            tx_par <= !cfg.even_par;
          end
        end
        TX_START, TX_DATA: begin
          if (tx_end && tx_state == TX_DATA && tx_bit == bits_last) begin
            tx_state <= cfg.par_en ? TX_PARITY : TX_STOP;
            txd <= cfg.par_en ? tx_par : 1'b1;
            tx_bit <= 3'h0;
          end else if (tx_end) begin
            tx_bit <= (tx_state == TX_START) ? 3'h0 : tx_bit + 3'h1;
            tx_state <= TX_DATA;
            txd <= tx_shift[0];
            tx_par <= tx_par ^ tx_shift[0];
            tx_shift <= tx_shift >> 1;
          end
        end
        TX_PARITY: begin
          if (tx_end) begin
            tx_state <= TX_STOP;
            txd <= 1'b1;
          end
        end
        TX_STOP: begin
          if (tx_end && cfg.two_stop && !tx_bit[0]) begin
            tx_bit <= 3'h1;
          end else if (tx_end) begin
            tx_state <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  wire logic rx_sample = baud_tick && (rx_tick == sample_pt);
  wire logic rx_end = baud_tick && (rx_tick == os_last);
  wire logic [7:0] rx_aligned = rx_shift >> (BITS_PAD - {1'b0, cfg.wlen});

  // Stop is checked once at mid-bit; further stop bits are not looked at,
  // which also leaves half a bit of margin to catch the next start edge.
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state <= RX_IDLE;
      rx_tick <= 5'h00;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_par <= 1'b0;
      rx_par_err <= 1'b0;
      rxd_prev <= 1'b1;
      rx_push_valid <= 1'b0;
      rx_entry <= '0;
    end else begin
      rxd_prev <= rxd;
      rx_push_valid <= 1'b0;
      if (baud_tick) begin
        rx_tick <= rx_end ? 5'h00 : rx_tick + TICK_ONE;
      end
      case (rx_state)
        RX_IDLE: begin
          if (rxd_prev && !rxd) begin
            rx_state <= RX_START;
            rx_tick <= 5'h00;
            rx_par <= !cfg.even_par;
            rx_par_err <= 1'b0;
          end
        end
        RX_START: begin
          if (rx_sample && rxd) begin
            rx_state <= RX_IDLE;
          end else if (rx_end) begin
            rx_state <= RX_DATA;
            rx_bit <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_shift <= {rxd, rx_shift[7:1]};
            rx_par <= rx_par ^ rxd;
          end
          if (rx_end && rx_bit == bits_last) begin
            rx_state <= cfg.par_en ? RX_PARITY : RX_STOP;
          end else if (rx_end) begin
            rx_bit <= rx_bit + 3'h1;
          end
        end
        RX_PARITY: begin
          if (rx_sample) begin
            rx_par_err <= (rx_par != rxd);
          end
          if (rx_end) begin
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            rx_state <= RX_IDLE;
            rx_push_valid <= 1'b1;
            rx_entry.data <= rx_aligned;
            rx_entry.par_err <= rx_par_err;
            rx_entry.frame_err <= !rxd;
            rx_entry.brk <= !rxd && (rx_aligned == 8'h00);
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------
  entry_fifo #(.WIDTH(8)) tx_fifo (
    .clk(clk), .reset(reset), .flush(mode_flush), .single(!cfg.fifo_mode),
    .push_valid(wr_data && w_strb[0]), .push_ready(tx_push_ready),
    .push_data(w_data[7:0]), .pop_valid(tx_pop_valid), .pop_ready(tx_state == TX_IDLE),
    .pop_data(tx_pop_data), .count(tx_count)
  );

  entry_fifo #(.WIDTH($bits(rx_entry_t))) rx_fifo (
    .clk(clk), .reset(reset), .flush(mode_flush), .single(!cfg.fifo_mode),
    .push_valid(rx_push_valid), .push_ready(rx_push_ready),
    .push_data(rx_entry), .pop_valid(rx_pop_valid), .pop_ready(rd_data),
    .pop_data(rx_pop_data), .count(rx_count)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Transmit-empty is also raised when its enable is switched on while
  // empty, otherwise software enabling it late would wait forever.
  wire logic tx_empty_ev = (tx_pop_fire && tx_count == CNT_ONE)
    || (wr_mask && w_data[INT_TX_EMPTY] && !int_mask[INT_TX_EMPTY] && !tx_pop_valid);
  wire logic [INT_W-1:0] int_ev = {rx_push_valid && !rx_push_ready,
    rx_push_valid && (rx_entry.par_err || rx_entry.frame_err || rx_entry.brk),
    tx_empty_ev, rx_push_valid && rx_push_ready};
  wire logic [INT_W-1:0] int_clr = rd_int_id ? {INT_W{1'b1}}
    : (tx_push_fire ? {{(INT_W-2){1'b0}}, 2'b10} : '0);

  // Set wins over clear so an event in the clearing cycle is kept.
  always_ff @(posedge clk) begin
    if (reset) begin
      int_status <= '0;
      irq <= 1'b0;
    end else begin
      int_status <= (int_status & ~int_clr) | int_ev;
      irq <= |(int_status & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_tx_launch;
    tx_state == TX_IDLE && tx_pop_valid;
  endsequence
  sequence s_ar_take;
    arvalid && arready;
  endsequence

  a_tx_idle_line: assert property (tx_state == TX_IDLE |-> txd)
    else $error("line not high while transmitter idle");
  a_tx_start_bit: assert property (s_tx_launch |=> !txd && tx_state == TX_START)
    else $error("frame did not open with a low start bit");
  a_baud_spacing: assert property ((baud_tick && div_last != 16'h0000) |=> !baud_tick)
    else $error("baud tick repeated too soon");
  a_rx_false_start: assert property (
    (rx_state == RX_START && rx_sample && rxd) |=> rx_state == RX_IDLE && !rx_push_valid)
    else $error("glitch was accepted as a start bit");
  a_irq_follow: assert property (##1 irq == $past(|(int_status & int_mask)))
    else $error("interrupt output does not follow enabled status");
  a_tx_empty_raise: assert property ((tx_pop_fire && tx_count == CNT_ONE) |=>
    int_status[INT_TX_EMPTY])
    else $error("transmit empty event was lost");
  a_tx_empty_clear: assert property ((tx_push_fire && !tx_empty_ev) |=>
    !int_status[INT_TX_EMPTY])
    else $error("loading a byte did not clear transmit empty");
  a_read_answer: assert property (s_ar_take |=> rvalid && !arready)
    else $error("read was not answered next cycle");

  // Ticks since the last mid-bit sample, counted apart from the bit counter,
  // so a wrap of the tick counter at the wrong count is caught.
  logic [4:0] rx_since_sample;
  always_ff @(posedge clk) begin
    if (reset || rx_sample) begin
      rx_since_sample <= 5'h00;
    end else if (baud_tick) begin
      rx_since_sample <= rx_since_sample + TICK_ONE;
    end
  end

  a_rx_sample_pt: assert property ((rx_state == RX_DATA && rx_sample) |->
    rx_since_sample == os_last)
    else $error("data bit samples are not one bit apart");

endmodule
`default_nettype wire

// file: test/serial_peer.sv
// Remote serial device: sends frames on rxd and captures frames from txd.
// Assumes bits are paced by the core clock; bit_len is clock cycles per bit.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  int bit_len = 16;
  logic [7:0] got = 8'h00;
  initial rxd = 1'b1;
  // Start low, data LSB first, then one stop bit at level s.
  task automatic send(input logic [7:0] b, input logic s);
    logic [9:0] f;
    f = {s, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bit_len) @(posedge clk);
    end
    rxd <= 1'b1;
    @(posedge clk);
  endtask
  // A short low pulse that the receiver must not take for a start bit.
  task automatic pulse(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge clk);
    rxd <= 1'b1;
    repeat (bit_len) @(posedge clk);
  endtask
  // Each data bit is taken at its middle to tolerate edge skew.
  always begin
    @(negedge txd);
    repeat (bit_len / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_len) @(posedge clk);
      got[i] = txd;
    end
    repeat (bit_len) @(posedge clk);
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the serial core: register bus, both serial directions.
// Assumes the peer model stands on the serial pins; divisor 1, or 2 for 13x.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uart_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic rxd, txd, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  int fails = 0, samples_checked = 0;
  uart_fifo_baud_core i_uart_fifo_baud_core (.clk(clk), .reset(reset), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .rxd(rxd), .txd(txd), .irq(irq));
  serial_peer i_serial_peer (.clk(clk), .txd(txd), .rxd(rxd));
  initial forever #20 clk = ~clk;
  // Verdict is printed here only.
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", what, e, g);
      fails++;
    end
  endtask
  // Bus cycles hold each channel until its own handshake edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 60);
    bready <= 1'b0;
    if (n == 60) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 60);
    d = rdata;
    rready <= 1'b0;
    if (n == 60) begin
      fails++;
      tally_and_finish();
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(ADDR_CTRL);
    chk("ctrl", 32'h0000_0000, d);
    rd(ADDR_DIVISOR);
    chk("divisor", 32'h0000_0001, d);
    rd(ADDR_STATUS);
    chk("status", 32'h0000_000A, d);
    rd(8'h20);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rresp});
    wr(8'h20, 32'h0000_0000);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, bresp});
    wr(ADDR_DIVISOR, 32'h0000_A55A);
    rd(ADDR_DIVISOR);
    chk("divisor bytes", 32'h0000_A55A, d);
    $display("test reset done");
  endtask
  // Eight-bit frame out of txd; the peer's bit length is divisor times ticks per bit.
  task automatic t_tx(input logic [31:0] c, input logic [31:0] dv, input int len,
    input logic [7:0] b);
    i_serial_peer.bit_len = len;
    wr(ADDR_DIVISOR, dv);
    wr(ADDR_CTRL, c);
    wr(ADDR_DATA, {24'h0, b});
    repeat (11 * len) @(posedge clk);
    chk("tx byte", {24'h0, b}, {24'h0, i_serial_peer.got});
    chk("tx idle", 32'h1, {31'h0, txd});
    $display("test tx done");
  endtask
  task automatic t_rx_irq();
    int n;
    wr(ADDR_INT_MASK, 32'h0000_0001);
    i_serial_peer.pulse(3);
    rd(ADDR_STATUS);
    chk("glitch ignored", 32'h0, d & 32'h1);
    i_serial_peer.send(8'h3C, 1'b1);
    for (n = 0; n < 40 && irq !== 1'b1; n++) @(posedge clk);
    chk("irq set", 32'h1, {31'h0, irq});
    rd(ADDR_INT_ID);
    chk("rx event", 32'h1, d & 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    rd(ADDR_DATA);
    chk("rx byte", 32'h0000_003C, d);
    $display("test rx irq done");
  endtask
  // Buffered mode keeps both entries, each with its own error bits.
  task automatic t_fifo();
    i_serial_peer.bit_len = 16;
    wr(ADDR_DIVISOR, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_000D);
    i_serial_peer.send(8'h11, 1'b1);
    i_serial_peer.send(8'h00, 1'b0);
    repeat (16) @(posedge clk);
    rd(ADDR_DATA);
    chk("first entry", 32'h0000_0011, d);
    rd(ADDR_DATA);
    chk("break entry", 32'h0000_0600, d);
    $display("test fifo done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_tx(32'h0000_000C, 32'h0000_0001, 16, 8'hA5);
    t_tx(32'h0000_000E, 32'h0000_0002, 26, 8'h5A);
    t_rx_irq();
    t_fifo();
    tally_and_finish();
  end
endmodule
`default_nettype wire
